// ===== hw/sioc_channel.sv
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module sioc_channel
  import sioc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Processor and data channel
  sioc_link_if.chan link,
  // Control unit selection and control
  output logic [3:0] cu_unit,
  output logic [3:0] cu_device,
  output logic [7:0] cu_command,
  output logic cu_start,
  output logic cu_halt,
  output logic cu_disconnect,
  // Control unit service requests
  input wire logic cu_service_req,
  input wire logic [15:0] cu_addr_status,
  output logic cu_service_ack,
  // Control unit data
  output logic [15:0] cu_wdata,
  output logic cu_wvalid,
  input wire logic cu_wready,
  input wire logic [15:0] cu_rdata,
  input wire logic cu_rvalid,
  output logic cu_rready,
  // Console
  input wire logic console_reset
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_CU_START, ST_XFER_MEM, ST_XFER_DEV, ST_END
  } sioc_state_type;

  sioc_state_type state;
  logic [1:0] fetch_idx;
  logic [15:0] channel_address_register;
  logic [15:0] byte_count;
  logic [15:0] unit_status;
  logic poll_allowed;
  logic usp;
  logic cede;
  logic chk;
  logic end_event;
  logic svc_meta;
  logic svc_sync;
  logic con_meta;
  logic con_sync;
  logic accept;
  logic is_halt;
  logic is_sense;
  logic start_ok;
  logic svc_take;
  logic bad_cmd;
  logic is_write;
  logic is_read;
  logic [15:0] sense_word;

  function automatic logic [15:0] next_count(input logic [15:0] c);
    next_count = (c <= 16'h0002) ? 16'h0000 : c - 16'h0002;
  endfunction : next_count

  assign accept = link.cmd_valid && !link.cmd_done && link.cmd_area == AREA_CODE;
  assign is_halt = accept && link.cmd_func == FN_HALT;
  assign is_sense = accept && link.cmd_func == FN_SENSE;
  assign start_ok = accept && link.cmd_func == FN_START && state == ST_IDLE;
  // Requests wait unanswered while polling is off
  assign svc_take = poll_allowed && svc_sync && !cu_service_ack && state == ST_IDLE
                    && !accept;
  assign is_write = cu_command[1:0] == CMD_WRITE;
  assign is_read = cu_command[1:0] == CMD_READ;
  assign bad_cmd = state == ST_CU_START && !is_write && !is_read;

  always_comb begin
    sense_word = 16'h0000;
    case (link.cmd_mod[13:14])
      2'h0: begin
        sense_word[S0_USP] = usp;
        sense_word[S0_CEDE] = cede;
        sense_word[S0_CHK] = chk;
        sense_word[S0_POLL] = poll_allowed;
        sense_word[S0_BUSY] = state != ST_IDLE;
      end
      2'h1: sense_word = byte_count;
      2'h2: sense_word = unit_status;
      default: sense_word = channel_address_register;
    endcase
  end

  // Service request and console reset come from off-chip
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_meta <= 1'b0;
      svc_sync <= 1'b0;
      con_meta <= 1'b0;
      con_sync <= 1'b0;
    end else begin
      svc_meta <= cu_service_req;
      svc_sync <= svc_meta;
      con_meta <= console_reset;
      con_sync <= con_meta;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.cmd_done <= 1'b0;
      link.cmd_rdata <= 16'h0000;
    end else begin
      link.cmd_done <= accept;
      if (is_sense) begin
        link.cmd_rdata <= sense_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      poll_allowed <= 1'b1;
    end else if (con_sync || is_halt) begin
      poll_allowed <= 1'b1;
    end else if (is_sense) begin
      poll_allowed <= !link.cmd_mod[12];
    end else if (start_ok || svc_take) begin
      poll_allowed <= 1'b0;
    end
  end

  // Indicators: a new event outranks a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      usp <= 1'b0;
      cede <= 1'b0;
      chk <= 1'b0;
      unit_status <= 16'h0000;
      link.usp_pulse <= 1'b0;
      cu_service_ack <= 1'b0;
    end else begin
      link.usp_pulse <= svc_take || end_event;
      cu_service_ack <= svc_take;
      if (svc_take) begin
        unit_status <= cu_addr_status;
      end else if (end_event) begin
        unit_status <= {cu_unit, cu_device, UST_CE_DE};
      end
      if (svc_take || end_event) begin
        usp <= 1'b1;
      end else if (is_sense && link.cmd_mod[15]) begin
        usp <= 1'b0;
      end
      if (end_event) begin
        cede <= 1'b1;
      end else if (is_sense && link.cmd_mod[15]) begin
        cede <= 1'b0;
      end
      if (bad_cmd) begin
        chk <= 1'b1;
      end else if (is_sense && link.cmd_mod[15]) begin
        chk <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      fetch_idx <= 2'h0;
      channel_address_register <= 16'h0000;
      byte_count <= 16'h0000;
      cu_unit <= 4'h0;
      cu_device <= 4'h0;
      cu_command <= 8'h00;
      cu_start <= 1'b0;
      cu_halt <= 1'b0;
      cu_disconnect <= 1'b0;
      cu_wdata <= 16'h0000;
      cu_wvalid <= 1'b0;
      cu_rready <= 1'b0;
      end_event <= 1'b0;
      link.cs_req <= 1'b0;
      link.cs_write <= 1'b0;
      link.cs_addr <= 16'h0000;
      link.cs_wdata <= 16'h0000;
    end else begin
      cu_start <= 1'b0;
      cu_halt <= 1'b0;
      cu_disconnect <= 1'b0;
      end_event <= 1'b0;
      if (link.cs_ack) begin
        link.cs_req <= 1'b0;
      end
      if (is_halt) begin
        // A steal already asked for is left to end on its own ack
        cu_wvalid <= 1'b0;
        cu_rready <= 1'b0;
        state <= ST_END;
        if (state == ST_IDLE) begin
          cu_unit <= link.cmd_mod[8:11];
          cu_device <= link.cmd_mod[12:15];
          cu_halt <= 1'b1;
        end else begin
          cu_disconnect <= 1'b1;
        end
      end else begin
        case (state)
          ST_IDLE: begin
            if (start_ok) begin
              cu_unit <= link.cmd_mod[8:11];
              cu_device <= link.cmd_mod[12:15];
              channel_address_register <= link.cmd_addr;
              fetch_idx <= 2'h0;
              link.cs_req <= 1'b1;
              link.cs_write <= 1'b0;
              link.cs_addr <= link.cmd_addr;
              state <= ST_FETCH;
            end
          end
          ST_FETCH: begin
            if (link.cs_ack) begin
              case (fetch_idx)
                DW_COUNT: byte_count <= link.cs_rdata;
                DW_CMD: cu_command <= link.cs_rdata[7:0];
                default: channel_address_register <= link.cs_rdata;
              endcase
              if (fetch_idx == 2'(DESC_WORDS - 1)) begin
                state <= ST_CU_START;
              end else begin
                fetch_idx <= fetch_idx + 2'h1;
                link.cs_req <= 1'b1;
                link.cs_addr <= link.cs_addr + 16'h0001;
              end
            end
          end
          ST_CU_START: begin
            if (bad_cmd || byte_count == 16'h0000) begin
              state <= ST_END;
            end else begin
              cu_start <= 1'b1;
              if (is_write) begin
                link.cs_req <= 1'b1;
                link.cs_write <= 1'b0;
                link.cs_addr <= channel_address_register;
                state <= ST_XFER_MEM;
              end else begin
                cu_rready <= 1'b1;
                state <= ST_XFER_DEV;
              end
            end
          end
          ST_XFER_MEM: begin
            if (link.cs_ack) begin
              if (is_write) begin
                cu_wdata <= link.cs_rdata;
                cu_wvalid <= 1'b1;
                state <= ST_XFER_DEV;
              end else begin
                channel_address_register <= channel_address_register + 16'h0001;
                byte_count <= next_count(byte_count);
                if (byte_count <= 16'h0002) begin
                  state <= ST_END;
                end else begin
                  cu_rready <= 1'b1;
                  state <= ST_XFER_DEV;
                end
              end
            end
          end
          ST_XFER_DEV: begin
            if (cu_wvalid && cu_wready) begin
              cu_wvalid <= 1'b0;
              channel_address_register <= channel_address_register + 16'h0001;
              byte_count <= next_count(byte_count);
              if (byte_count <= 16'h0002) begin
                state <= ST_END;
              end else begin
                link.cs_req <= 1'b1;
                link.cs_addr <= channel_address_register + 16'h0001;
                state <= ST_XFER_MEM;
              end
            end else if (cu_rready && cu_rvalid) begin
              cu_rready <= 1'b0;
              link.cs_req <= 1'b1;
              link.cs_write <= 1'b1;
              link.cs_addr <= channel_address_register;
              // Odd count: unused right byte is stored as zero
              link.cs_wdata <= (byte_count == 16'h0001) ? {cu_rdata[15:8], 8'h00} : cu_rdata;
              state <= ST_XFER_MEM;
            end
          end
          ST_END: begin
            end_event <= 1'b1;
            link.cs_write <= 1'b0;
            state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule : sioc_channel
`default_nettype wire

// ===== hw/sioc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sioc_link_if;
  // Command from processor, held until cmd_done
  logic cmd_valid;
  logic [4:0] cmd_area;
  logic [1:0] cmd_func;
  logic [8:15] cmd_mod;
  logic [15:0] cmd_addr;
  logic cmd_done;
  logic [15:0] cmd_rdata;
  // Cycle-steal core access, held until cs_ack
  logic cs_req;
  logic cs_write;
  logic [15:0] cs_addr;
  logic [15:0] cs_wdata;
  logic cs_ack;
  logic [15:0] cs_rdata;
  // Unit status pending event
  logic usp_pulse;

  modport chan(
    input cmd_valid, cmd_area, cmd_func, cmd_mod, cmd_addr, cs_ack, cs_rdata,
    output cmd_done, cmd_rdata, cs_req, cs_write, cs_addr, cs_wdata, usp_pulse
  );
  modport proc(
    output cmd_valid, cmd_area, cmd_func, cmd_mod, cmd_addr, cs_ack, cs_rdata,
    input cmd_done, cmd_rdata, cs_req, cs_write, cs_addr, cs_wdata, usp_pulse
  );
endinterface : sioc_link_if
`default_nettype wire

// ===== hw/sioc_pkg.sv
package sioc_pkg;
  // Area code that addresses this channel
  localparam logic [4:0] AREA_CODE = 5'h12;
  // Command function codes on the link
  localparam logic [1:0] FN_HALT = 2'h1;
  localparam logic [1:0] FN_SENSE = 2'h2;
  localparam logic [1:0] FN_START = 2'h3;
  // Descriptor layout and command codes
  localparam int DESC_WORDS = 3;
  localparam logic [1:0] DW_COUNT = 2'h0;
  localparam logic [1:0] DW_CMD = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  // Channel-end plus device-end unit status
  localparam logic [7:0] UST_CE_DE = 8'h0c;
  // Status word 0 bit positions
  localparam int S0_USP = 0;
  localparam int S0_CEDE = 1;
  localparam int S0_CHK = 2;
  localparam int S0_POLL = 3;
  localparam int S0_BUSY = 4;
  // Controller register offsets
  localparam logic [11:0] R_CMD = 12'h000;
  localparam logic [11:0] R_ADDR = 12'h004;
  localparam logic [11:0] R_STAT = 12'h008;
  localparam logic [11:0] R_IRQ = 12'h00c;
  localparam logic [11:0] R_MASK = 12'h010;
  localparam logic [11:0] MEM_BASE = 12'h400;
  localparam int MEM_WORDS = 256;
  // Command register fields
  localparam int CF_FUNC_LO = 16;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_USP = 1;
endpackage : sioc_pkg

// ===== hw/sioc_processor.sv
`timescale 1ns/100ps
`default_nettype none
module sioc_processor
  import sioc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Interrupt
  output logic irq,
  // Channel link
  sioc_link_if.proc link
);
  logic [15:0] core_mem [MEM_WORDS];
  logic ph_valid;
  logic ph_write;
  logic [11:0] ph_addr;
  logic [15:0] io_addr;
  logic [15:0] accum;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_status;
  logic cs_go;
  logic ph_mem;
  logic ahb_go;
  logic wr_go;
  logic [31:0] rd_word;

  // Cycle steals take the core first; a bus access to core memory waits
  assign cs_go = link.cs_req && !link.cs_ack;
  assign ph_mem = ph_addr >= MEM_BASE;
  assign ahb_go = ph_valid && !(cs_go && ph_mem);
  assign wr_go = ahb_go && ph_write;

  always_comb begin
    next_irq_status = irq_status;
    if (wr_go && ph_addr == R_IRQ) begin
      next_irq_status = irq_status & ~hwdata[1:0];
    end
    if (link.cmd_valid && link.cmd_done) begin
      next_irq_status[IRQ_DONE] = 1'b1;
    end
    if (link.usp_pulse) begin
      next_irq_status[IRQ_USP] = 1'b1;
    end
  end

  always_comb begin
    case (ph_addr)
      R_ADDR: rd_word = {16'h0000, io_addr};
      R_STAT: rd_word = {accum, 15'h0000, link.cmd_valid};
      R_IRQ: rd_word = {30'h0, irq_status};
      R_MASK: rd_word = {30'h0, irq_mask};
      default: rd_word = ph_mem ? {16'h0000, core_mem[ph_addr[9:2]]} : 32'h0;
    endcase
  end

  // Address phase is taken once; the data phase ends on hreadyout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 12'h000;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end else if (ahb_go) begin
      ph_valid <= 1'b0;
      hreadyout <= 1'b1;
      if (!ph_write) begin
        hrdata <= rd_word;
      end
    end else if (!ph_valid && hsel && htrans[1] && hready) begin
      ph_valid <= 1'b1;
      ph_write <= hwrite;
      ph_addr <= {haddr[11:2], 2'b00};
      hreadyout <= 1'b0;
    end
  end

  always_ff @(posedge hclk) begin
    if (cs_go && link.cs_write) begin
      core_mem[link.cs_addr[7:0]] <= link.cs_wdata;
    end else if (wr_go && ph_mem) begin
      core_mem[ph_addr[9:2]] <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.cs_ack <= 1'b0;
      link.cs_rdata <= 16'h0000;
    end else begin
      link.cs_ack <= cs_go;
      if (cs_go) begin
        link.cs_rdata <= core_mem[link.cs_addr[7:0]];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.cmd_valid <= 1'b0;
      link.cmd_area <= AREA_CODE;
      link.cmd_func <= 2'h0;
      link.cmd_mod <= 8'h00;
      link.cmd_addr <= 16'h0000;
      io_addr <= 16'h0000;
      accum <= 16'h0000;
    end else begin
      if (link.cmd_valid && link.cmd_done) begin
        link.cmd_valid <= 1'b0;
        if (link.cmd_func == FN_SENSE) begin
          accum <= link.cmd_rdata;
        end
      end
      if (wr_go && ph_addr == R_ADDR) begin
        io_addr <= hwdata[15:0];
      end
      // One command in flight; function code zero sends nothing
      if (wr_go && ph_addr == R_CMD && !link.cmd_valid
          && hwdata[CF_FUNC_LO+1:CF_FUNC_LO] != 2'h0) begin
        link.cmd_valid <= 1'b1;
        link.cmd_area <= AREA_CODE;
        link.cmd_func <= hwdata[CF_FUNC_LO+1:CF_FUNC_LO];
        link.cmd_mod <= hwdata[7:0];
        link.cmd_addr <= io_addr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
      if (wr_go && ph_addr == R_MASK) begin
        irq_mask <= hwdata[1:0];
      end
    end
  end
endmodule : sioc_processor
`default_nettype wire

// ===== tb/selector_io_channel_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module selector_io_channel_control_tb
  import sioc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [3:0] cu_unit, cu_device;
  logic [7:0] cu_command;
  logic cu_start, cu_halt, cu_disconnect, cu_service_req, cu_service_ack;
  logic cu_wvalid, cu_wready, cu_rvalid, cu_rready, console_reset, rd_on, wr_on;
  logic [15:0] cu_addr_status, cu_wdata, cu_rdata;
  logic [15:0] src [0:3];
  logic [15:0] got_wq [$];
  logic [15:0] exp_wq [$];
  int err_count, samples_checked, n_ack, n_start, n_halt, n_disc, n_usp, ri;
  int m_poll, m_usp, m_cede, m_chk;
  integer seed = 32'hb4dfce9a;

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  sioc_link_if sioc_link_if_inst();
  sioc_processor sioc_processor_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
    .link(sioc_link_if_inst.proc));
  sioc_channel sioc_channel_inst (.hclk(hclk), .hresetn(hresetn),
    .link(sioc_link_if_inst.chan), .cu_unit(cu_unit), .cu_device(cu_device),
    .cu_command(cu_command), .cu_start(cu_start), .cu_halt(cu_halt),
    .cu_disconnect(cu_disconnect), .cu_service_req(cu_service_req),
    .cu_addr_status(cu_addr_status), .cu_service_ack(cu_service_ack), .cu_wdata(cu_wdata),
    .cu_wvalid(cu_wvalid), .cu_wready(cu_wready), .cu_rdata(cu_rdata), .cu_rvalid(cu_rvalid),
    .cu_rready(cu_rready), .console_reset(console_reset));
  sioc_link_properties sioc_link_properties_inst (.hclk(hclk), .hresetn(hresetn),
    .cmd_valid(sioc_link_if_inst.cmd_valid), .cmd_area(sioc_link_if_inst.cmd_area),
    .cmd_func(sioc_link_if_inst.cmd_func), .cmd_mod(sioc_link_if_inst.cmd_mod),
    .cmd_addr(sioc_link_if_inst.cmd_addr), .cmd_done(sioc_link_if_inst.cmd_done),
    .cmd_rdata(sioc_link_if_inst.cmd_rdata), .cs_req(sioc_link_if_inst.cs_req),
    .cs_write(sioc_link_if_inst.cs_write), .cs_addr(sioc_link_if_inst.cs_addr),
    .cs_wdata(sioc_link_if_inst.cs_wdata), .cs_ack(sioc_link_if_inst.cs_ack),
    .cs_rdata(sioc_link_if_inst.cs_rdata), .usp_pulse(sioc_link_if_inst.usp_pulse));

  // Control unit side: random stalls on both data handshakes
  always @(posedge hclk) begin
    if (cu_service_ack === 1'b1) n_ack++;
    if (cu_start === 1'b1) n_start++;
    if (cu_halt === 1'b1) n_halt++;
    if (cu_disconnect === 1'b1) n_disc++;
    if (sioc_link_if_inst.usp_pulse === 1'b1) n_usp++;
    if (cu_wvalid === 1'b1 && cu_wready === 1'b1) got_wq.push_back(cu_wdata);
    if (cu_rvalid === 1'b1 && cu_rready === 1'b1) ri++;
    cu_rdata <= src[ri[1:0]];
    cu_rvalid <= rd_on && (($random(seed) & 1) != 0);
    cu_wready <= wr_on && (($random(seed) & 1) != 0);
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic mw(input logic [7:0] a, input logic [15:0] d);
    ahb(1'b1, MEM_BASE + {2'h0, a, 2'h0}, {16'h0, d});
  endtask : mw

  task automatic desc(input logic [7:0] a, input logic [15:0] cnt, input logic [7:0] c,
                      input logic [15:0] da);
    mw(a, cnt);
    mw(a + 8'h1, {8'h0, c});
    mw(a + 8'h2, da);
    ahb(1'b1, R_ADDR, {24'h0, a});
  endtask : desc

  task automatic cmd(input logic [1:0] f, input logic [7:0] m);
    int i;
    ahb(1'b1, R_CMD, {14'h0, f, 8'h0, m});
    ahb(1'b0, R_STAT, 32'h0);
    for (i = 0; i < 40 && r[0] !== 1'b0; i++) ahb(1'b0, R_STAT, 32'h0);
    chk("cmd_pending", {31'h0, r[0]}, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : cmd

  // Results are compared only when the sense leaves polling and indicators alone
  task automatic sense(input logic b12, input logic [1:0] w, input logic clr,
                       input logic [15:0] e);
    logic cmp;
    logic [15:0] ex;
    cmp = (b12 == (m_poll == 0)) && !clr;
    ex = (w == 2'h0) ? {11'h0, 1'b0, m_poll[0], m_chk[0], m_cede[0], m_usp[0]} : e;
    cmd(FN_SENSE, {4'h0, b12, w, clr});
    if (cmp) chk("sense_word", {16'h0, r[31:16]}, {16'h0, ex});
    if (clr) m_usp = 0;
    if (clr) m_cede = 0;
    if (clr) m_chk = 0;
    m_poll = !b12;
  endtask : sense

  task automatic wait_usp(input int n);
    int i;
    for (i = 0; i < 3000 && n_usp < n; i++) @(posedge hclk);
    chk("usp_count", n_usp, n);
  endtask : wait_usp

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  initial begin
    #(40 * 40000);
    err_count++;
    close_out();
  end

  initial begin
    int i;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, console_reset} = '0;
    {cu_service_req, cu_addr_status, cu_wready, cu_rdata, cu_rvalid, rd_on, wr_on} = '0;
    {err_count, samples_checked, n_ack, n_start, n_halt, n_disc, n_usp, ri} = '0;
    {m_poll, m_usp, m_cede} = {32'd1, 32'd0, 32'd0};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, R_STAT, 32'h0);
    chk("stat_reset", r, 32'h0);
    ahb(1'b1, 12'h020, 32'hffffffff);
    ahb(1'b0, 12'h020, 32'h0);
    chk("unmapped", r, 32'h0);
    ahb(1'b1, R_MASK, 32'h3);
    sense(1'b0, 2'h0, 1'b0, 16'h0);
    sense(1'b1, 2'h0, 1'b0, 16'h0);
    sense(1'b1, 2'h0, 1'b0, 16'h0);
    ahb(1'b1, R_IRQ, 32'h3);
    chk("irq_idle", {31'h0, irq}, 32'h0);
    // Service request while polling is off, then freed by console reset
    cu_addr_status <= $random(seed);
    cu_service_req <= 1'b1;
    repeat (20) @(posedge hclk);
    chk("ack_held", n_ack, 0);
    // Short press: a one-cycle console reset turns polling back on and the request is taken
    console_reset <= 1'b1;
    @(posedge hclk);
    console_reset <= 1'b0;
    for (i = 0; i < 200 && n_ack < 1; i++) @(posedge hclk);
    chk("service_ack", n_ack, 1);
    cu_service_req <= 1'b0;
    {m_poll, m_usp} = {32'd0, 32'd1};
    wait_usp(1);
    repeat (2) @(posedge hclk);
    chk("irq_raised", {31'h0, irq}, 32'h1);
    sense(1'b1, 2'h2, 1'b0, cu_addr_status);
    sense(1'b1, 2'h0, 1'b0, 16'h0);
    sense(1'b1, 2'h0, 1'b1, 16'h0);
    sense(1'b1, 2'h0, 1'b0, 16'h0);
    ahb(1'b1, R_MASK, 32'h0);
    // Irq follows a new mask one cycle later
    @(posedge hclk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    ahb(1'b1, R_MASK, 32'h3);
    ahb(1'b1, R_IRQ, 32'h3);
    ahb(1'b0, R_IRQ, 32'h0);
    chk("irq_status", r, 32'h0);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    // Write burst, with a second start while the first is stalled
    exp_wq = {$random(seed), $random(seed)};
    mw(8'h50, exp_wq[0]);
    mw(8'h51, exp_wq[1]);
    desc(8'h40, 16'h0004, CMD_WRITE, 16'h0050);
    cmd(FN_START, 8'h5a);
    ahb(1'b1, R_ADDR, 32'h60);
    cmd(FN_START, 8'h36);
    wr_on = 1'b1;
    wait_usp(2);
    chk("unit_dev_cmd", {8'h0, cu_unit, cu_device, 8'h0, cu_command}, 32'h5a0001);
    chk("start_count", n_start, 1);
    chk("write_words", got_wq.size(), 2);
    foreach (exp_wq[k]) chk("write_data", {16'h0, got_wq[k]}, {16'h0, exp_wq[k]});
    {m_usp, m_cede} = {32'd1, 32'd1};
    sense(1'b1, 2'h2, 1'b0, 16'h5a0c);
    // Read burst of an odd byte count
    src[0] = $random(seed);
    src[1] = $random(seed);
    desc(8'h60, 16'h0003, CMD_READ, 16'h0070);
    rd_on = 1'b1;
    cmd(FN_START, 8'h3c);
    wait_usp(3);
    ahb(1'b0, MEM_BASE + 12'h1c0, 32'h0);
    chk("read_word0", r, {16'h0, src[0]});
    ahb(1'b0, MEM_BASE + 12'h1c4, 32'h0);
    chk("read_word1", r, {16'h0, src[1][15:8], 8'h00});
    // Halt while the device never delivers data
    rd_on = 1'b0;
    desc(8'h80, 16'h0004, CMD_READ, 16'h0090);
    cmd(FN_START, 8'h11);
    for (i = 0; i < 200 && n_start < 3; i++) @(posedge hclk);
    cmd(FN_HALT, 8'hff);
    wait_usp(4);
    chk("busy_disc", n_disc, 1);
    chk("busy_no_halt", n_halt, 0);
    m_poll = 1;
    sense(1'b0, 2'h0, 1'b0, 16'h0);
    sense(1'b0, 2'h1, 1'b0, 16'h0004);
    sense(1'b0, 2'h3, 1'b0, 16'h0090);
    cmd(FN_HALT, 8'h27);
    wait_usp(5);
    chk("idle_halt", n_halt, 1);
    chk("idle_sel", {24'h0, cu_unit, cu_device}, 32'h27);
    // Unknown command code sets the check indicator; software then halts
    desc(8'ha0, 16'h0002, 8'h00, 16'h00b0);
    cmd(FN_START, 8'h12);
    wait_usp(6);
    chk("bad_no_start", n_start, 3);
    {m_poll, m_chk} = {32'd0, 32'd1};
    sense(1'b1, 2'h0, 1'b0, 16'h0);
    cmd(FN_HALT, 8'h00);
    wait_usp(7);
    m_poll = 1;
    sense(1'b0, 2'h0, 1'b1, 16'h0);
    sense(1'b0, 2'h0, 1'b0, 16'h0);
    close_out();
  end
endmodule : selector_io_channel_control_tb
`default_nettype wire

// ===== tb/sioc_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sioc_link_properties
  import sioc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Command link
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_area,
  input wire logic [1:0] cmd_func,
  input wire logic [8:15] cmd_mod,
  input wire logic [15:0] cmd_addr,
  input wire logic cmd_done,
  input wire logic [15:0] cmd_rdata,
  // Cycle steal and events
  input wire logic cs_req,
  input wire logic cs_write,
  input wire logic [15:0] cs_addr,
  input wire logic [15:0] cs_wdata,
  input wire logic cs_ack,
  input wire logic [15:0] cs_rdata,
  input wire logic usp_pulse
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_area_fixed: assert property (cmd_valid |-> cmd_area == AREA_CODE)
    else $error("command sent with foreign area code");
  a_done_cause: assert property (cmd_done |-> $past(cmd_valid && !cmd_done && cmd_area == AREA_CODE))
    else $error("command done without an addressed command");
  a_cmd_answer: assert property (cmd_valid && !cmd_done && cmd_area == AREA_CODE |=> cmd_done)
    else $error("command not answered in one cycle");
  a_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("command done wider than one cycle");
  a_cmd_hold: assert property (cmd_valid && !cmd_done |=>
    cmd_valid && $stable(cmd_func) && $stable(cmd_mod) && $stable(cmd_addr))
    else $error("command changed before done");
  a_steal_hold: assert property (cs_req && !cs_ack |=>
    cs_req && $stable(cs_addr) && $stable(cs_write) && $stable(cs_wdata))
    else $error("steal request changed before ack");
  a_steal_answer: assert property (cs_req && !cs_ack |=> cs_ack)
    else $error("steal not acknowledged in one cycle");
  a_ack_cause: assert property (cs_ack |-> $past(cs_req && !cs_ack))
    else $error("steal ack without a fresh request");
endmodule : sioc_link_properties
`default_nettype wire
